// ### include/cvd_pkg.sv
// constants and types shared by the converter sequencer and its clock source
package cvd_pkg;

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [9:0] MAIN_CTRL_IDX  = 10'h3F3;
  localparam logic [9:0] SENSE_CTRL_IDX = 10'h3F4;
  localparam logic [9:0] PRE_TIME_IDX   = 10'h3E8;
  localparam logic [9:0] ACQ_TIME_IDX   = 10'h3E9;
  localparam logic [9:0] CAP_SEL_IDX    = 10'h3EA;
  localparam logic [9:0] CLK_DIV_IDX    = 10'h3EB;
  localparam logic [9:0] STOP_CTRL_IDX  = 10'h3EC;
  localparam logic [9:0] RESULT_IDX     = 10'h3ED;
  localparam logic [9:0] PREV_IDX       = 10'h3EE;
  localparam logic [9:0] STATUS_IDX     = 10'h3EF;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned ON_BIT   = 7;
  localparam int unsigned CONTINUOUS_CONVERSION_BIT = 6;
  localparam int unsigned CS_BIT   = 4;
  localparam int unsigned FM_BIT   = 2;
  localparam int unsigned GO_BIT   = 0;
  localparam int unsigned PRECHARGE_POLARITY_BIT = 7;
  localparam int unsigned INVERTED_PRECHARGE_ENABLE_BIT = 6;
  localparam int unsigned GUARD_POLARITY_BIT = 5;
  localparam int unsigned DOUBLE_SAMPLE_ENABLE_BIT = 0;
  localparam int unsigned SOI_BIT  = 0;

  // ----------------------------------------------------------------------
  // reset values and counts
  // ----------------------------------------------------------------------
  localparam logic [7:0] MAIN_CTRL_RST  = 8'h00;
  localparam logic [7:0] SENSE_CTRL_RST = 8'h00;
  localparam logic [7:0] TIME_RST       = 8'h00;
  localparam logic [5:0] CAP_SEL_RST    = 6'h00;
  localparam logic [5:0] CLK_DIV_RST    = 6'h00;
  localparam logic [11:0] RESULT_RST    = 12'h000;
  // longest acquisition, in conversion-clock ticks, for a zero setting
  localparam logic [8:0] ACQ_MAX_TICKS  = 9'h100;
  // conversion phase length in conversion-clock ticks
  localparam logic [8:0] CONV_TICKS     = 9'h00E;

  typedef enum {SEQ_IDLE, SEQ_PRE, SEQ_ACQ, SEQ_CONV} seq_state_t;

endpackage

// ### include/conv_clk_if.sv
// conversion clock request and tick between sequencer and clock source
`timescale 1ns/1ps
interface conv_clk_if;
  logic       rc_select;
  logic [5:0] divider;
  logic       run;
  logic       tick;

  modport gen (input rc_select, input divider, input run, output tick);
  modport seq (output rc_select, output divider, output run, input tick);
endinterface

// ### verilog/conv_clock_gen.sv
// conversion clock tick source: dedicated oscillator or divided system clock
`timescale 1ns/1ps
module conv_clock_gen
  import cvd_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic rc_clk_in,
  conv_clk_if.gen   cc
);

  logic [2:0] rc_sync;
  logic       rc_level;
  logic       rc_level_prev;
  logic [5:0] div_cnt;
  logic       div_tick;
  logic       rc_tick;

  // ----------------------------------------------------------------------
  // oscillator input crossing
  // ----------------------------------------------------------------------
  // a change is taken only once the second and third stages agree
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rc_sync       <= 3'h0;
      rc_level      <= 1'b0;
      rc_level_prev <= 1'b0;
    end
    else if (ce)
    begin
      rc_sync       <= {rc_sync[1:0], rc_clk_in};
      rc_level      <= (rc_sync[2] == rc_sync[1]) ? rc_sync[2] : rc_level;
      rc_level_prev <= rc_level;
    end
  end

  assign rc_tick = rc_level & ~rc_level_prev;

  // ----------------------------------------------------------------------
  // system clock divider
  // ----------------------------------------------------------------------
  assign div_tick = (div_cnt == cc.divider);

  always_ff @(posedge clk)
  begin
    if (rst)
      div_cnt <= 6'h00;
    else if (ce)
      div_cnt <= (!cc.run || div_tick) ? 6'h00 : div_cnt + 6'h01;
  end

  assign cc.tick = cc.run & (cc.rc_select ? rc_tick : div_tick);

endmodule // conv_clock_gen

// ### verilog/adc_cvd_guard_control.sv
// converter sequencer with precharge, acquisition, guard outputs and APB registers
`timescale 1ns/1ps
module adc_cvd_guard_control
  import cvd_pkg::*;
(
  input  wire  logic        clk,
  input  wire  logic        rst,
  input  wire  logic        ce,
  input  wire  logic        psel,
  input  wire  logic        penable,
  input  wire  logic        pwrite,
  input  wire  logic [11:0] paddr,
  input  wire  logic [31:0] pwdata,
  output logic       [31:0] prdata,
  output logic              pready,
  output logic              pslverr,
  input  wire  logic        rc_clk_in,
  input  wire  logic [11:0] analog_result,
  input  wire  logic        threshold_flag,
  output logic              guard_out_a,
  output logic              guard_out_b,
  output logic              pin_drive_en,
  output logic              pin_drive_level,
  output logic              hold_tie_en,
  output logic              hold_tie_level,
  output logic              sample_connect,
  output logic              extra_cap_en,
  output logic       [5:0]  extra_cap_sel,
  output logic              converting,
  output logic              conversion_done,
  output logic              compute_start
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [11:0] a, input logic [9:0] idx);
    return a == {idx, 2'b00};
  endfunction

  function automatic logic [15:0] align(input logic [11:0] v, input logic right);
    return right ? {4'h0, v} : {v, 4'h0};
  endfunction

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  logic        on;
  logic        continuous_conversion;
  logic        cs;
  logic        fm;
  logic        go;
  logic        precharge_polarity;
  logic        inverted_precharge_enable;
  logic        guard_polarity;
  logic        double_sample_enable;
  logic        stop_on_threshold;
  logic [7:0]  precharge_time;
  logic [7:0]  acquisition_time;
  logic [5:0]  extra_hold_cap_select;
  logic [5:0]  clock_divider_select;
  logic [11:0] result_value;
  logic [11:0] previous_result;
  seq_state_t  state;
  logic [8:0]  cnt;
  logic        second;

  conv_clk_if cc ();

  conv_clock_gen u_clk (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .rc_clk_in (rc_clk_in),
    .cc        (cc)
  );

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  wire hit_main   = hit(paddr, MAIN_CTRL_IDX);
  wire hit_sense  = hit(paddr, SENSE_CTRL_IDX);
  wire hit_pre    = hit(paddr, PRE_TIME_IDX);
  wire hit_acq    = hit(paddr, ACQ_TIME_IDX);
  wire hit_cap    = hit(paddr, CAP_SEL_IDX);
  wire hit_div    = hit(paddr, CLK_DIV_IDX);
  wire hit_stop   = hit(paddr, STOP_CTRL_IDX);
  wire hit_res    = hit(paddr, RESULT_IDX);
  wire hit_prev   = hit(paddr, PREV_IDX);
  wire hit_stat   = hit(paddr, STATUS_IDX);
  wire hit_any    = hit_main | hit_sense | hit_pre | hit_acq | hit_cap | hit_div
                  | hit_stop | hit_res | hit_prev | hit_stat;
  wire wr_en      = psel & penable & pwrite & ce;
  wire rd_setup   = psel & ~penable & ~pwrite;
  wire wr_main    = wr_en & hit_main;
  wire wr_sense   = wr_en & hit_sense;

  // always ready; read data is latched in the setup cycle
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire [7:0] main_rd = {on, continuous_conversion, 1'b0, cs, 1'b0, fm, 1'b0, go};
  wire [7:0] sense_rd = {precharge_polarity, inverted_precharge_enable, guard_polarity, 4'h0, double_sample_enable};
  wire [31:0] rd_mux =
      hit_main  ? {24'h0, main_rd} :
      hit_sense ? {24'h0, sense_rd} :
      hit_pre   ? {24'h0, precharge_time} :
      hit_acq   ? {24'h0, acquisition_time} :
      hit_cap   ? {26'h0, extra_hold_cap_select} :
      hit_div   ? {26'h0, clock_divider_select} :
      hit_stop  ? {31'h0, stop_on_threshold} :
      hit_res   ? {16'h0, align(result_value, fm)} :
      hit_prev  ? {16'h0, align(previous_result, fm)} :
      hit_stat  ? {29'h0, second, (state != SEQ_IDLE), converting} :
      32'h0;

  always_ff @(posedge clk)
  begin
    if (rst)
      prdata <= 32'h0;
    else if (ce && rd_setup)
      prdata <= rd_mux;
  end

  // ----------------------------------------------------------------------
  // start bit control
  // ----------------------------------------------------------------------
  wire next_on     = wr_main ? pwdata[ON_BIT] : on;
  wire sw_go_set   = wr_main & pwdata[GO_BIT] & pwdata[ON_BIT];
  wire sw_go_clr   = wr_main & ~pwdata[GO_BIT];
  wire stop_req    = (sw_go_clr & ~sw_go_set) | ~next_on;
  wire phase_end   = cc.tick && (cnt == 9'h001);
  wire running     = (state != SEQ_IDLE);
  wire seq_start   = (state == SEQ_IDLE) && go && !stop_req;
  wire conv_complete = (state == SEQ_CONV) && phase_end && !stop_req;
  wire abort       = running && sw_go_clr && !sw_go_set && next_on;
  wire thr_stop    = stop_on_threshold & threshold_flag;
  wire hw_go_clr   = conv_complete & (~continuous_conversion | thr_stop);
  // a software set in the same cycle as a hardware clear wins
  wire next_go     = sw_go_set ? 1'b1 : (stop_req | hw_go_clr) ? 1'b0 : go;

  // ----------------------------------------------------------------------
  // register writes
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {on, continuous_conversion, cs, fm} <= {MAIN_CTRL_RST[ON_BIT], MAIN_CTRL_RST[CONTINUOUS_CONVERSION_BIT],
                             MAIN_CTRL_RST[CS_BIT], MAIN_CTRL_RST[FM_BIT]};
      go   <= MAIN_CTRL_RST[GO_BIT];
      {precharge_polarity, inverted_precharge_enable, guard_polarity, double_sample_enable} <= {SENSE_CTRL_RST[PRECHARGE_POLARITY_BIT], SENSE_CTRL_RST[INVERTED_PRECHARGE_ENABLE_BIT],
                                   SENSE_CTRL_RST[GUARD_POLARITY_BIT], SENSE_CTRL_RST[DOUBLE_SAMPLE_ENABLE_BIT]};
      stop_on_threshold                   <= 1'b0;
      precharge_time        <= TIME_RST;
      acquisition_time      <= TIME_RST;
      extra_hold_cap_select <= CAP_SEL_RST;
      clock_divider_select  <= CLK_DIV_RST;
    end
    else if (ce)
    begin
      go <= next_go;
      if (wr_main)
      begin
        on   <= pwdata[ON_BIT];
        continuous_conversion <= pwdata[CONTINUOUS_CONVERSION_BIT];
        cs   <= pwdata[CS_BIT];
        fm   <= pwdata[FM_BIT];
      end
      if (wr_sense)
      begin
        precharge_polarity <= pwdata[PRECHARGE_POLARITY_BIT];
        inverted_precharge_enable <= pwdata[INVERTED_PRECHARGE_ENABLE_BIT];
        guard_polarity <= pwdata[GUARD_POLARITY_BIT];
        double_sample_enable <= pwdata[DOUBLE_SAMPLE_ENABLE_BIT];
      end
      if (wr_en && hit_stop)
        stop_on_threshold <= pwdata[SOI_BIT];
      if (wr_en && hit_pre)
        precharge_time <= pwdata[7:0];
      if (wr_en && hit_acq)
        acquisition_time <= pwdata[7:0];
      if (wr_en && hit_cap)
        extra_hold_cap_select <= pwdata[5:0];
      if (wr_en && hit_div)
        clock_divider_select <= pwdata[5:0];
    end
  end

  // ----------------------------------------------------------------------
  // conversion clock selection
  // ----------------------------------------------------------------------
  assign cc.rc_select = cs;
  assign cc.divider   = clock_divider_select;
  assign cc.run       = running;

  // ----------------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------------
  // second member of an inverted pair flips precharge and guard levels
  wire invert      = double_sample_enable & inverted_precharge_enable & second;
  wire base_lvl    = guard_polarity ^ invert;
  wire pre_nz      = (precharge_time != 8'h00);
  wire acq_nz      = (acquisition_time != 8'h00);
  wire [8:0] acq_load = acq_nz ? {1'b0, acquisition_time} : ACQ_MAX_TICKS;
  wire pre_to_acq  = (state == SEQ_PRE) && phase_end && !stop_req;
  wire acq_to_conv = (state == SEQ_ACQ) && phase_end && !stop_req;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state           <= SEQ_IDLE;
      cnt             <= 9'h000;
      second          <= 1'b0;
      guard_out_a     <= 1'b0;
      guard_out_b     <= 1'b0;
      result_value    <= RESULT_RST;
      previous_result <= RESULT_RST;
    end
    else if (ce)
    begin
      if (!next_on)
      begin
        state       <= SEQ_IDLE;
        second      <= 1'b0;
        guard_out_a <= 1'b0;
        guard_out_b <= 1'b0;
      end
      else if (abort)
      begin
        state        <= SEQ_IDLE;
        second       <= 1'b0;
        result_value <= analog_result;
      end
      else if (seq_start)
      begin
        previous_result <= result_value;
        guard_out_b     <= base_lvl;
        if (pre_nz)
        begin
          state       <= SEQ_PRE;
          cnt         <= {1'b0, precharge_time};
          guard_out_a <= base_lvl;
        end
        else if (acq_nz)
        begin
          state       <= SEQ_ACQ;
          cnt         <= {1'b0, acquisition_time};
          guard_out_a <= ~base_lvl;
        end
        else
        begin
          // no hardware acquisition timing when precharge and acquisition times are both zero
          state       <= SEQ_CONV;
          cnt         <= CONV_TICKS;
          guard_out_a <= ~base_lvl;
        end
      end
      else if (pre_to_acq)
      begin
        state       <= SEQ_ACQ;
        cnt         <= acq_load;
        guard_out_a <= ~guard_out_a;
      end
      else if (acq_to_conv)
      begin
        state <= SEQ_CONV;
        cnt   <= CONV_TICKS;
      end
      else if (conv_complete)
      begin
        state        <= SEQ_IDLE;
        result_value <= analog_result;
        second       <= double_sample_enable & ~second;
      end
      else if (running && cc.tick)
        cnt <= cnt - 9'h001;
    end
  end

  // ----------------------------------------------------------------------
  // analog switch controls
  // ----------------------------------------------------------------------
  wire in_pre = (state == SEQ_PRE);
  assign pin_drive_en    = in_pre;
  assign pin_drive_level = in_pre & (precharge_polarity ^ invert);
  assign hold_tie_en     = in_pre;
  assign hold_tie_level  = in_pre & ~(precharge_polarity ^ invert);
  assign sample_connect  = (state == SEQ_ACQ);
  // extra capacitance only while sampling, never during conversion
  assign extra_cap_en    = (state == SEQ_ACQ);
  assign extra_cap_sel   = extra_cap_en ? extra_hold_cap_select : 6'h00;
  assign converting      = (state == SEQ_CONV);
  assign conversion_done = conv_complete;
  assign compute_start   = conv_complete & (~double_sample_enable | second);

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (rst || !ce);

  guards_off_a: assert property (!on |-> (!guard_out_a && !guard_out_b && !pin_drive_en))
    else $error("guard or pin override active while disabled");
  pre_guard_a: assert property (seq_start && pre_nz |=>
      (guard_out_a == $past(base_lvl)) && (guard_out_b == $past(base_lvl)))
    else $error("guards not at start level in precharge");
  acq_invert_a: assert property (pre_to_acq |=>
      (guard_out_a != $past(guard_out_a)) && $stable(guard_out_b))
    else $error("guard A not inverted at acquisition");
  acq_release_a: assert property ((state == SEQ_ACQ) |-> (!pin_drive_en && sample_connect))
    else $error("drivers held or channel open in acquisition");
  cap_conv_off_a: assert property (converting |-> (!extra_cap_en && extra_cap_sel == 6'h00))
    else $error("extra capacitance during conversion");
  go_needs_on_a: assert property (!on |-> !go)
    else $error("start bit set while disabled");
  single_clear_a: assert property (conv_complete && !continuous_conversion && !sw_go_set |=> !go ##1 !running)
    else $error("start bit not cleared after single conversion");
  continuous_conversion_retrig_a: assert property (conv_complete && continuous_conversion && !thr_stop && !wr_main |=>
      go ##1 running)
    else $error("continuous mode failed to retrigger");
  abort_reset_a: assert property (abort |-> !conversion_done ##1 (!running && !compute_start))
    else $error("abort did not reset without done");
  pre_skip_a: assert property (seq_start && !pre_nz |=> !in_pre)
    else $error("precharge not skipped at zero time");
  pair_compute_a: assert property (conv_complete && double_sample_enable && !second |-> !compute_start)
    else $error("computation on first of a pair");

endmodule // adc_cvd_guard_control

// ### sim/sensor_model.sv
// sensor pin model feeding converter data
`timescale 1ns/1ps
module sensor_model #(
  parameter logic [11:0] HI = 12'hB6D,
  parameter logic [11:0] LO = 12'h2C4
) (
  input  wire logic        clk,
  input  wire logic        pin_drive_en,
  input  wire logic        pin_drive_level,
  input  wire logic        converting,
  output logic      [11:0] analog_result
);
  logic        lvl   = 1'b0;
  logic [11:0] noise = 12'h000;

  // sensor keeps the level it was precharged to
  always @(posedge clk)
  begin
    noise <= noise + 12'h5A3;
    if (pin_drive_en)
      lvl <= pin_drive_level;
  end

  // outside conversion the data bus floats: walking pattern that steps through every code, the last one included
  assign analog_result = converting ? (lvl ? HI : LO) : noise;
endmodule // sensor_model

// ### sim/adc_cvd_guard_control_bench.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (e)); end end
module adc_cvd_guard_control_bench;
  import cvd_pkg::*;
  localparam logic [11:0] HI = 12'hB6D;
  localparam logic [11:0] LO = 12'h2C4;
  logic        clk = 0, rst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic        rc_clk_in = 0, threshold_flag = 0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000, analog_result;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic        guard_out_a, guard_out_b, pin_drive_en, pin_drive_level, hold_tie_en;
  logic        hold_tie_level, sample_connect, extra_cap_en, converting;
  logic        conversion_done, compute_start, pd_q = 0, sc_q = 0, cv_q = 0, rc_run = 0;
  logic [5:0]  extra_cap_sel, cs;
  logic [1:0]  g_pre, g_acq, lv_pre;
  logic [6:0]  cap;
  bit          gp, pp;
  int          n_fail = 0, checks_done = 0, cyc = 0, pre_len, acq_len, conv_len;
  int          pre_n = 0, acq_n = 0, done_n = 0, comp_n = 0, cap_bad = 0;
  int          i, k, d, c, e, p, a;

  adc_cvd_guard_control i_adc_cvd_guard_control (.clk, .rst, .ce, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rc_clk_in, .analog_result,
    .threshold_flag, .guard_out_a, .guard_out_b, .pin_drive_en, .pin_drive_level,
    .hold_tie_en, .hold_tie_level, .sample_connect, .extra_cap_en, .extra_cap_sel,
    .converting, .conversion_done, .compute_start);
  sensor_model #(.HI(HI), .LO(LO)) i_sensor_model (.clk, .pin_drive_en, .pin_drive_level,
    .converting, .analog_result);

  always #2.5 clk = ~clk;

  // ----
  // phase monitor and timeout
  // ----
  always @(posedge clk)
  begin
    cyc++;
    if (pin_drive_en && !pd_q)
    begin
      pre_len = 0;
      pre_n++;
      g_pre = {guard_out_a, guard_out_b};
      lv_pre = {pin_drive_level, hold_tie_level};
    end
    if (sample_connect && !sc_q)
    begin
      acq_len = 0;
      acq_n++;
      g_acq = {guard_out_a, guard_out_b};
      cap = {extra_cap_en, extra_cap_sel};
    end
    if (converting && !cv_q)
      conv_len = 0;
    pre_len += pin_drive_en;
    acq_len += sample_connect;
    conv_len += converting;
    cap_bad += converting & extra_cap_en;
    done_n += conversion_done;
    comp_n += compute_start;
    pd_q = pin_drive_en;
    sc_q = sample_connect;
    cv_q = converting;
    if (rc_run && cyc % 4 == 0)
      rc_clk_in <= ~rc_clk_in;
    if (cyc == 40000)
    begin
      n_fail++;
      complete_run();
    end
  end

  // ----
  // bus and run helpers
  // ----
  task automatic apb(input bit wr, input logic [9:0] idx, input logic [31:0] wd);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // write main control, then wait for n more completions
  task automatic launch(input logic [7:0] m, input int n);
    d = done_n + n;
    apb(1, MAIN_CTRL_IDX, {24'h0, m});
    for (k = 0; k < 3000 && done_n < d; k++) @(posedge clk);
    repeat (3) @(posedge clk);
  endtask

  task automatic cfg(input int pre, input int acq, input logic [7:0] sense);
    apb(1, PRE_TIME_IDX, 32'(pre));
    apb(1, ACQ_TIME_IDX, 32'(acq));
    apb(1, SENSE_CTRL_IDX, {24'h0, sense});
  endtask

  function automatic logic [31:0] code(input bit lvl, input bit fm);
    logic [11:0] r;
    r = lvl ? HI : LO;
    return fm ? {20'h0, r} : {16'h0, r, 4'h0};
  endfunction

  task automatic complete_run();
    $display("comparisons %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ----
  // scenarios
  // ----
  initial
  begin
    void'($urandom(11506));
    repeat (2) @(posedge clk);
    rst <= 0;
    apb(0, SENSE_CTRL_IDX, 32'h0);
    `CHK(rv, 32'h0)
    apb(1, PRE_TIME_IDX, 32'h2);
    apb(1, MAIN_CTRL_IDX, 32'h01);
    repeat (40) @(posedge clk);
    apb(0, MAIN_CTRL_IDX, 32'h0);
    `CHK(rv, 32'h0)
    `CHK(done_n, 0)
    apb(0, 10'h000, 32'h0);
    `CHK({err, rv}, 33'h1_0000_0000)
    for (i = 0; i < 4; i++)
    begin
      p = $urandom_range(4, 1);
      a = $urandom_range(4, 1);
      gp = $urandom;
      pp = $urandom;
      cs = 6'($urandom_range(63, 1));
      apb(1, CAP_SEL_IDX, {26'h0, cs});
      cfg(p, a, {pp, 1'b0, gp, 5'h0});
      launch({5'b10000, i[0], 2'b01}, 1);
      `CHK(g_pre, {gp, gp})
      `CHK(lv_pre, {pp, !pp})
      `CHK(g_acq, {!gp, gp})
      `CHK(pre_len, p)
      `CHK(acq_len, a)
      `CHK(cap, {1'b1, cs})
      `CHK(conv_len, 14)
      apb(0, RESULT_IDX, 32'h0);
      `CHK(rv, code(pp, i[0]))
      apb(0, MAIN_CTRL_IDX, 32'h0);
      `CHK(rv[7:0], {5'b10000, i[0], 2'b00})
    end
    cfg(1, 1, 8'h00);
    apb(1, CLK_DIV_IDX, 32'h2);
    launch(8'h81, 1);
    `CHK(conv_len, 42)
    apb(1, CLK_DIV_IDX, 32'h0);
    rc_run <= 1;
    launch(8'h91, 1);
    `CHK(conv_len, 112)
    rc_run <= 0;
    cfg(1, 0, 8'h00);
    launch(8'h81, 1);
    `CHK(acq_len, 256)
    cfg(0, 0, 8'h00);
    c = pre_n;
    e = acq_n;
    launch(8'h81, 1);
    `CHK(pre_n - c, 0)
    `CHK(acq_n - e, 0)
    gp = $urandom;
    pp = $urandom;
    cfg(2, 2, {pp, 1'b1, gp, 4'h0, 1'b1});
    c = comp_n;
    launch(8'h85, 1);
    `CHK(comp_n - c, 0)
    launch(8'h85, 1);
    `CHK(g_pre, {!gp, !gp})
    `CHK(g_acq, {gp, !gp})
    `CHK(lv_pre, {!pp, pp})
    `CHK(comp_n - c, 1)
    apb(0, PREV_IDX, 32'h0);
    `CHK(rv, code(pp, 1))
    apb(0, RESULT_IDX, 32'h0);
    `CHK(rv, code(!pp, 1))
    cfg(1, 1, 8'h00);
    apb(1, STOP_CTRL_IDX, 32'h0);
    launch(8'hC1, 2);
    apb(0, MAIN_CTRL_IDX, 32'h0);
    `CHK(rv[0], 1'b1)
    for (k = 0; k < 100 && converting; k++) @(posedge clk);
    for (k = 0; k < 100 && !converting; k++) @(posedge clk);
    c = done_n;
    e = comp_n;
    apb(1, MAIN_CTRL_IDX, 32'hC0);
    repeat (30) @(posedge clk);
    `CHK(done_n - c, 0)
    `CHK(comp_n - e, 0)
    apb(0, MAIN_CTRL_IDX, 32'h0);
    `CHK(rv[0], 1'b0)
    apb(0, RESULT_IDX, 32'h0);
    `CHK(rv, code(0, 0))
    apb(1, STOP_CTRL_IDX, 32'h1);
    threshold_flag <= 1;
    launch(8'hC1, 1);
    c = done_n;
    repeat (60) @(posedge clk);
    `CHK(done_n - c, 0)
    apb(0, MAIN_CTRL_IDX, 32'h0);
    `CHK(rv[0], 1'b0)
    threshold_flag <= 0;
    cfg(200, 1, 8'h20);
    launch(8'h81, 0);
    repeat (10) @(posedge clk);
    // a disable written while the clock enable is low must be dropped
    ce <= 0;
    apb(1, MAIN_CTRL_IDX, 32'h0);
    ce <= 1;
    apb(0, STATUS_IDX, 32'h0);
    `CHK(rv, 32'h2)
    apb(1, MAIN_CTRL_IDX, 32'h0);
    @(posedge clk);
    #1;
    `CHK({guard_out_a, guard_out_b, pin_drive_en, hold_tie_en, sample_connect}, 5'h0)
    `CHK(cap_bad, 0)
    complete_run();
  end
endmodule // adc_cvd_guard_control_bench
